// File: src/pcs_pkg.sv
// Purpose: shared constants for the preset cycling sequencer
// Assumes: classic wishbone slave, 32-bit data, byte addresses
// Notes: register map and field layouts
package pcs_pkg;
  localparam int PRESET_W = 4;
  localparam int CNT_W = 16;
  localparam int EXP_W = 24;
  localparam int NUM_PRESETS = 16;
  localparam int NUM_OUT = 2;
  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_TOTAL = 8'h04;
  localparam logic [7:0] REG_REPEAT = 8'h08;
  localparam logic [7:0] REG_EDIT = 8'h0C;
  localparam logic [7:0] REG_EXPO = 8'h10;
  localparam logic [7:0] REG_PULSE = 8'h14;
  localparam logic [7:0] REG_STATUS = 8'h18;
  localparam logic [7:0] REG_SWCMD = 8'h1C;
  localparam logic [7:0] REG_NORMEXP = 8'h20;
  // control field positions
  localparam int CTRL_EN = 0;
  localparam int CTRL_ADV_LSB = 4;
  localparam int CTRL_RWD_LSB = 8;
  localparam int EDIT_MEMBER = 8;
  localparam int EDIT_MEMEN = 12;
  localparam int SW_ADV = 0;
  localparam int SW_RWD = 1;
  // reset values
  localparam logic [PRESET_W-1:0] TOTAL_RST = 4'h1;
  localparam logic [CNT_W-1:0] REPEAT_RST = 16'h0001;
  localparam logic [EXP_W-1:0] EXP_RST = 24'h0003E8;
  localparam logic [31:0] BAD_ADDR_DATA = 32'h00000000;
  // pulse width on exposure begin
  localparam int PULSE_NS = 1000;
  localparam int CLK_NS = 100;
  localparam int PULSE_CYC = (PULSE_NS + CLK_NS - 1) / CLK_NS;
  typedef enum logic [2:0] {
    ADV_FRAME, ADV_TRIG, ADV_TIMER, ADV_PIN, ADV_SOFT
  } pcs_adv_t;
  typedef enum logic [1:0] {
    RWD_NONE, RWD_ACQ_STOP, RWD_SOFT, RWD_PIN
  } pcs_rwd_t;
  localparam logic [3:0] MEMBER_EXPOSURE = 4'h0;
  localparam logic [3:0] MEMBER_PULSE = 4'h1;
endpackage

// File: src/pcs_pulse.sv
// Purpose: fixed-width pulse stretcher for one output pin
// Assumes: fire is a one-cycle strobe on clock_i
// Notes: retriggers on a new fire
`timescale 1ns/1ps
module pcs_pulse #(
  parameter int WIDTH = pcs_pkg::PULSE_CYC
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic srst_i,
  // strobe and pulse
  input wire logic fire_i,
  output logic pulse_o
);
  typedef struct packed {
    logic [7:0] cnt;
    logic pulse;
  } pcs_pst_t;
  pcs_pst_t st_r;
  pcs_pst_t st_nxt;
  always_comb begin
    st_nxt = st_r;
    if (fire_i) begin
      st_nxt.cnt = 8'(WIDTH - 1);
      st_nxt.pulse = 1'b1;
    end else if (st_r.cnt != 8'h00) begin
      st_nxt.cnt = st_r.cnt - 8'h01;
    end else begin
      st_nxt.pulse = 1'b0;
    end
  end
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign pulse_o = st_r.pulse;
endmodule

// File: src/pcs_sequencer.sv
// Purpose: steps exposure and pulse presets on counted events
// Assumes: frame and exposure strobes are on clock_i; pins are not
// Notes: wishbone classic slave, one wait state per access
//
// Chosen here: the register addresses and register access over Wishbone.
`timescale 1ns/1ps
// Operation
// RULE_01 - cycle only while cycle_enable is set
// RULE_02 - index wraps from preset_total to one
// RULE_03 - advance after events_per_step counted events
// RULE_04 - frame begin and accepted trigger synchronous
// RULE_05 - timer, pin and software are asynchronous
// RULE_06 - selectable rewind event returns index to one
// RULE_07 - synchronous source: rewind waits next increment
// RULE_08 - asynchronous source: rewind applies at once
// RULE_09 - edit selected preset feature when member enabled
// RULE_10 - cycling exposure from preset, normal read-only
// RULE_11 - writes to idle preset never disturb cycling
// RULE_12 - each preset has own output pulse line
// RULE_13 - burst of two frames steps two presets
// RULE_14 - pulse on every exposure begin event
// RULE_15 - rewind also clears event counter
module pcs_sequencer #(
  parameter int NPRE = pcs_pkg::NUM_PRESETS,
  parameter int NOUT = pcs_pkg::NUM_OUT
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic srst_i,
  // wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // acquisition timing events, same clock
  input wire logic frame_begin_event_i,
  input wire logic accepted_trigger_event_i,
  input wire logic exposure_begin_i,
  input wire logic acquisition_stop_event_i,
  // asynchronous sources
  input wire logic timer_done_event_i,
  input wire logic input_pin_event_i,
  // preset outputs
  output logic [pcs_pkg::PRESET_W-1:0] active_preset_o,
  output logic [pcs_pkg::EXP_W-1:0] exposure_duration_o,
  output logic [NOUT-1:0] out_pin_o
);
  localparam int PW = pcs_pkg::PRESET_W;
  localparam int EW = pcs_pkg::EXP_W;
  localparam int CW = pcs_pkg::CNT_W;

  typedef struct packed {
    logic cycle_enable;
    pcs_pkg::pcs_adv_t adv_sel;
    pcs_pkg::pcs_rwd_t rwd_sel;
    logic [PW-1:0] preset_total;
    logic [CW-1:0] events_per_step;
    logic [PW-1:0] edit_index;
    logic [3:0] member_sel;
    logic mem_exp_en;
    logic mem_pulse_en;
    logic [EW-1:0] norm_exp;
    logic [NPRE-1:0][EW-1:0] exp_tab;
    logic [NPRE-1:0][NOUT-1:0] pulse_tab;
    logic [PW-1:0] idx;
    logic [CW-1:0] evcnt;
    logic rwd_pend;
    logic [2:0] tim_s;
    logic [2:0] pin_s;
    logic ack;
    logic [31:0] rdat;
    logic [EW-1:0] exp_out;
  } pcs_st_t;

  pcs_st_t st_r;
  pcs_st_t st_nxt;
  logic [NOUT-1:0] fire;
  logic acc;
  logic sync_src;
  logic adv_ev;
  logic rwd_ev;
  logic sw_adv;
  logic sw_rwd;
  logic tim_rise;
  logic pin_rise;
  logic [PW-1:0] next_idx;
  logic rwd_now;
  logic rwd_on_adv;
  logic [CW-1:0] evcnt_inc;
  logic cnt_done;
  logic [31:0] rd_ctrl;
  logic [31:0] rd_edit;

  // an access is taken once, ack blocks a second take
  assign acc = wb_cyc_i && wb_stb_i && !st_r.ack;
  assign sw_adv = acc && wb_we_i && wb_sel_i[0]
    && wb_adr_i == pcs_pkg::REG_SWCMD && wb_dat_i[pcs_pkg::SW_ADV];
  assign sw_rwd = acc && wb_we_i && wb_sel_i[0]
    && wb_adr_i == pcs_pkg::REG_SWCMD && wb_dat_i[pcs_pkg::SW_RWD];
  // edge detect reads only synchronised stages
  assign tim_rise = st_r.tim_s[1] && !st_r.tim_s[2];
  assign pin_rise = st_r.pin_s[1] && !st_r.pin_s[2];
  // frame-aligned sources are the synchronous class
  assign sync_src = st_r.adv_sel == pcs_pkg::ADV_FRAME
    || st_r.adv_sel == pcs_pkg::ADV_TRIG; // [RULE_04] [RULE_05]

  always_comb begin
    case (st_r.adv_sel)
      pcs_pkg::ADV_FRAME: adv_ev = frame_begin_event_i;
      pcs_pkg::ADV_TRIG: adv_ev = accepted_trigger_event_i;
      pcs_pkg::ADV_TIMER: adv_ev = tim_rise;
      pcs_pkg::ADV_PIN: adv_ev = pin_rise;
      pcs_pkg::ADV_SOFT: adv_ev = sw_adv;
      default: adv_ev = 1'b0;
    endcase
    case (st_r.rwd_sel)
      pcs_pkg::RWD_ACQ_STOP: rwd_ev = acquisition_stop_event_i; // [RULE_06]
      pcs_pkg::RWD_SOFT: rwd_ev = sw_rwd;
      pcs_pkg::RWD_PIN: rwd_ev = pin_rise;
      default: rwd_ev = 1'b0;
    endcase
  end

  // wrap from preset_total back to the first preset
  assign next_idx = (st_r.idx >= st_r.preset_total - PW'(1))
    ? '0 : st_r.idx + PW'(1); // [RULE_02]

  // asynchronous class rewinds at once
  assign rwd_now = rwd_ev && !sync_src; // [RULE_08]
  // synchronous class holds the rewind for the next increment
  assign rwd_on_adv = adv_ev
    && (st_r.rwd_pend || (rwd_ev && sync_src)); // [RULE_07]
  // step once the count reaches events_per_step
  assign evcnt_inc = st_r.evcnt + CW'(1);
  assign cnt_done = evcnt_inc >= st_r.events_per_step; // [RULE_03]

  // read words assembled from the field positions
  always_comb begin
    rd_ctrl = '0;
    rd_ctrl[pcs_pkg::CTRL_EN] = st_r.cycle_enable;
    rd_ctrl[pcs_pkg::CTRL_ADV_LSB +: 3] = st_r.adv_sel;
    rd_ctrl[pcs_pkg::CTRL_RWD_LSB +: 2] = st_r.rwd_sel;
    rd_edit = '0;
    rd_edit[PW-1:0] = st_r.edit_index;
    rd_edit[pcs_pkg::EDIT_MEMBER +: 4] = st_r.member_sel;
    rd_edit[pcs_pkg::EDIT_MEMEN] = st_r.mem_exp_en;
    rd_edit[pcs_pkg::EDIT_MEMEN + 1] = st_r.mem_pulse_en;
  end

  always_comb begin
    st_nxt = st_r;
    st_nxt.tim_s = {st_r.tim_s[1:0], timer_done_event_i};
    st_nxt.pin_s = {st_r.pin_s[1:0], input_pin_event_i};
    st_nxt.ack = acc;
    // sequencing
    if (!st_r.cycle_enable) begin
      st_nxt.idx = '0; // [RULE_01]
      st_nxt.evcnt = '0;
      st_nxt.rwd_pend = 1'b0;
    end else begin
      if (rwd_ev && sync_src) begin
        st_nxt.rwd_pend = 1'b1; // [RULE_07]
      end
      if (rwd_now) begin
        st_nxt.idx = '0; // [RULE_08]
        st_nxt.evcnt = '0; // [RULE_15]
        st_nxt.rwd_pend = 1'b0;
      end else if (rwd_on_adv) begin
        st_nxt.idx = '0; // [RULE_07]
        st_nxt.evcnt = '0; // [RULE_15]
        st_nxt.rwd_pend = 1'b0;
      end else if (adv_ev) begin
        // one event per frame, so with events_per_step of one a two-frame burst steps twice
        if (cnt_done) begin
          st_nxt.evcnt = '0; // [RULE_03] [RULE_13]
          st_nxt.idx = next_idx;
        end else begin
          st_nxt.evcnt = evcnt_inc; // [RULE_03]
        end
      end
    end
    // exposure source
    if (st_r.cycle_enable && st_r.mem_exp_en) begin
      st_nxt.exp_out = st_r.exp_tab[st_nxt.idx]; // [RULE_10]
    end else begin
      st_nxt.exp_out = st_r.norm_exp; // [RULE_01]
    end
    // register writes
    if (acc && wb_we_i) begin
      case (wb_adr_i)
        pcs_pkg::REG_CTRL: begin
          if (wb_sel_i[0]) begin
            st_nxt.cycle_enable = wb_dat_i[pcs_pkg::CTRL_EN];
            st_nxt.adv_sel = pcs_pkg::pcs_adv_t'(
              wb_dat_i[pcs_pkg::CTRL_ADV_LSB +: 3]);
          end
          if (wb_sel_i[1]) begin
            st_nxt.rwd_sel = pcs_pkg::pcs_rwd_t'(
              wb_dat_i[pcs_pkg::CTRL_RWD_LSB +: 2]);
          end
        end
        pcs_pkg::REG_TOTAL: begin
          if (wb_sel_i[0] && wb_dat_i[PW-1:0] != '0) begin
            st_nxt.preset_total = wb_dat_i[PW-1:0];
          end
        end
        pcs_pkg::REG_REPEAT: begin
          if (wb_sel_i[1:0] == 2'h3 && wb_dat_i[CW-1:0] != '0) begin
            st_nxt.events_per_step = wb_dat_i[CW-1:0];
          end
        end
        pcs_pkg::REG_EDIT: begin
          if (wb_sel_i[0]) begin
            st_nxt.edit_index = wb_dat_i[PW-1:0]; // [RULE_09]
          end
          if (wb_sel_i[1]) begin
            st_nxt.member_sel = wb_dat_i[pcs_pkg::EDIT_MEMBER +: 4];
            if (wb_dat_i[pcs_pkg::EDIT_MEMBER +: 4]
                == pcs_pkg::MEMBER_EXPOSURE) begin
              st_nxt.mem_exp_en = wb_dat_i[pcs_pkg::EDIT_MEMEN]; // [RULE_09]
            end else if (wb_dat_i[pcs_pkg::EDIT_MEMBER +: 4]
                == pcs_pkg::MEMBER_PULSE) begin
              st_nxt.mem_pulse_en = wb_dat_i[pcs_pkg::EDIT_MEMEN];
            end
          end
        end
        pcs_pkg::REG_EXPO: begin
          // per-preset store, free of the live index
          if (st_r.mem_exp_en && wb_sel_i == 4'hF) begin
            st_nxt.exp_tab[st_r.edit_index] = wb_dat_i[EW-1:0]; // [RULE_11]
          end
        end
        pcs_pkg::REG_PULSE: begin
          if (st_r.mem_pulse_en && wb_sel_i[0]) begin
            st_nxt.pulse_tab[st_r.edit_index] =
              wb_dat_i[NOUT-1:0]; // [RULE_12]
          end
        end
        pcs_pkg::REG_NORMEXP: begin
          // ignored while cycling owns exposure
          if (!(st_r.cycle_enable && st_r.mem_exp_en)
              && wb_sel_i == 4'hF) begin
            st_nxt.norm_exp = wb_dat_i[EW-1:0]; // [RULE_10]
          end
        end
        default: begin
        end
      endcase
    end
    // register reads
    st_nxt.rdat = pcs_pkg::BAD_ADDR_DATA;
    if (acc && !wb_we_i) begin
      case (wb_adr_i)
        pcs_pkg::REG_CTRL: st_nxt.rdat = rd_ctrl;
        pcs_pkg::REG_TOTAL: st_nxt.rdat = 32'(st_r.preset_total);
        pcs_pkg::REG_REPEAT: st_nxt.rdat = 32'(st_r.events_per_step);
        pcs_pkg::REG_EDIT: st_nxt.rdat = rd_edit;
        pcs_pkg::REG_EXPO: st_nxt.rdat = 32'(st_r.exp_tab[st_r.edit_index]);
        pcs_pkg::REG_PULSE:
          st_nxt.rdat = 32'(st_r.pulse_tab[st_r.edit_index]);
        pcs_pkg::REG_STATUS: st_nxt.rdat = 32'({st_r.rwd_pend,
          st_r.evcnt, 4'h0, st_r.idx});
        pcs_pkg::REG_NORMEXP: st_nxt.rdat = 32'(st_r.exp_out);
        default: st_nxt.rdat = pcs_pkg::BAD_ADDR_DATA;
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      st_r <= '0;
      st_r.preset_total <= pcs_pkg::TOTAL_RST;
      st_r.events_per_step <= pcs_pkg::REPEAT_RST;
      st_r.norm_exp <= pcs_pkg::EXP_RST;
      st_r.exp_out <= pcs_pkg::EXP_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // exposure begin fires the current preset's pulse lines
  genvar g;
  generate
    for (g = 0; g < NOUT; g++) begin : g_out
      assign fire[g] = exposure_begin_i && st_r.cycle_enable
        && st_r.mem_pulse_en
        && st_r.pulse_tab[st_r.idx][g]; // [RULE_12] [RULE_14]
      pcs_pulse u_pulse (
        .clock_i(clock_i),
        .srst_i(srst_i),
        .fire_i(fire[g]),
        .pulse_o(out_pin_o[g])
      );
    end
  endgenerate

  assign active_preset_o = st_r.idx + PW'(1);
  assign exposure_duration_o = st_r.exp_out;
  assign wb_ack_o = st_r.ack;
  assign wb_dat_o = st_r.rdat;
endmodule

// File: test/pcs_cam_model.sv
// Purpose: acquisition timing model driving the event lines
// Assumes: 0 frame, 1 trigger, 2 exposure, 3 stop, 4 timer, 5 pin
// Notes: asynchronous lines held high four cycles
`timescale 1ns/1ps
module pcs_cam_model (
  // clock
  input wire logic clock_i,
  // event lines
  output logic [5:0] ev_o
);
  initial ev_o = 6'h00;
  task automatic fire(input int k);
    @(posedge clock_i);
    ev_o[k] <= 1'b1;
    repeat ((k > 3) ? 4 : 1) @(posedge clock_i);
    ev_o[k] <= 1'b0;
  endtask
endmodule

// File: test/pcs_sequencer_assertions.sv
// Purpose: port checks for the preset sequencer
// Assumes: one clock, synchronous reset
// Notes: bound to every pcs_sequencer
`timescale 1ns/1ps
module pcs_sequencer_assertions #(
  parameter int NOUT = pcs_pkg::NUM_OUT
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic srst_i,
  // bus and events
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic frame_begin_event_i,
  input wire logic accepted_trigger_event_i,
  input wire logic exposure_begin_i,
  input wire logic acquisition_stop_event_i,
  input wire logic timer_done_event_i,
  input wire logic input_pin_event_i,
  // outputs
  input wire logic [pcs_pkg::PRESET_W-1:0] active_preset_o,
  input wire logic [pcs_pkg::EXP_W-1:0] exposure_duration_o,
  input wire logic [NOUT-1:0] out_pin_o
);
  logic [3:0] since_cause_r;
  logic [3:0] since_exp_r;
  logic cause;
  assign cause = wb_cyc_i | frame_begin_event_i | accepted_trigger_event_i
    | acquisition_stop_event_i | timer_done_event_i | input_pin_event_i;
  always_ff @(posedge clock_i) begin
    if (srst_i || cause) since_cause_r <= 4'h0;
    else if (since_cause_r != 4'hF) since_cause_r <= since_cause_r + 4'h1;
    if (srst_i || exposure_begin_i) since_exp_r <= 4'h0;
    else if (since_exp_r != 4'hF) since_exp_r <= since_exp_r + 4'h1;
  end
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (srst_i);
  sequence pulse_start_s;
    $rose(out_pin_o[0]);
  endsequence
  sequence pulse_high_s;
    out_pin_o[0] [*8] ##1 out_pin_o[0] [*2];
  endsequence
  ack_after_req_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
    |=> wb_ack_o) else $error("no ack");
  ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  idle_data_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("data without ack");
  preset_step_a: assert property ($changed(active_preset_o)
    |-> active_preset_o == $past(active_preset_o) + 4'h1
    || active_preset_o == 4'h1) else $error("bad preset step");
  preset_cause_a: assert property ($changed(active_preset_o)
    |-> since_cause_r < 4'h8) else $error("preset moved alone");
  expo_cause_a: assert property ($changed(exposure_duration_o)
    |-> since_cause_r < 4'h8) else $error("exposure moved alone");
  pulse_cause_a: assert property ($rose(|out_pin_o)
    |-> since_exp_r < 4'h4) else $error("pulse without exposure");
  pulse_width_a: assert property (pulse_start_s |-> pulse_high_s)
    else $error("pulse width");
  reset_value_a: assert property ($fell(srst_i) |-> active_preset_o == 4'h1
    && exposure_duration_o == pcs_pkg::EXP_RST) else $error("reset value");
endmodule
bind pcs_sequencer pcs_sequencer_assertions #(.NOUT(NOUT)) i_pcs_chk (
  .clock_i(clock_i), .srst_i(srst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .frame_begin_event_i(frame_begin_event_i),
  .accepted_trigger_event_i(accepted_trigger_event_i),
  .exposure_begin_i(exposure_begin_i),
  .acquisition_stop_event_i(acquisition_stop_event_i),
  .timer_done_event_i(timer_done_event_i),
  .input_pin_event_i(input_pin_event_i),
  .active_preset_o(active_preset_o),
  .exposure_duration_o(exposure_duration_o), .out_pin_o(out_pin_o));

// File: test/preset_cycling_sequencer_test.sv
// Purpose: self-checking bench for the preset sequencer
// Assumes: one wait state bus, events from pcs_cam_model
// Notes: small totals and repeat counts
`timescale 1ns/1ps
module preset_cycling_sequencer_test;
  logic clock_i = 1'b0;
  logic srst_i = 1'b1;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0;
  logic [31:0] q;
  logic [31:0] rdat;
  logic ack;
  logic [3:0] ap;
  logic [23:0] expo;
  logic [1:0] pin;
  logic [5:0] ev;
  int fails = 0;
  int num_checks = 0;
  int cycles = 0;
  logic [7:0] cfg_a [11] = '{8'h04, 8'h08, 8'h00, 8'h0C, 8'h10, 8'h0C,
    8'h10, 8'h0C, 8'h14, 8'h0C, 8'h14};
  logic [15:0] cfg_d [11] = '{16'h2, 16'h2, 16'h101, 16'h1000, 16'h100,
    16'h1001, 16'h200, 16'h1100, 16'h1, 16'h1101, 16'h2};
  initial forever #50 clock_i = ~clock_i;
  pcs_cam_model i_cam (.clock_i(clock_i), .ev_o(ev));
  pcs_sequencer i_dut (.clock_i(clock_i), .srst_i(srst_i),
    .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .frame_begin_event_i(ev[0]), .accepted_trigger_event_i(ev[1]),
    .exposure_begin_i(ev[2]), .acquisition_stop_event_i(ev[3]),
    .timer_done_event_i(ev[4]), .input_pin_event_i(ev[5]),
    .active_preset_o(ap), .exposure_duration_o(expo), .out_pin_o(pin));
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      $display("unexpected at %0t: got %h want %h", $time, g, e);
      fails++;
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
    @(posedge clock_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    @(posedge clock_i);
    while (ack !== 1'b1) @(posedge clock_i);
    q = rdat;
    cyc <= 1'b0;
  endtask
  task automatic ev_go(input int k);
    i_cam.fire(k);
    repeat (5) @(posedge clock_i);
  endtask
  task automatic sw(input logic [31:0] c);
    wb(1'b1, 8'h1C, c);
    repeat (3) @(posedge clock_i);
  endtask
  task automatic pulse(input logic [1:0] m);
    i_cam.fire(2);
    repeat (2) @(posedge clock_i);
    chk(pin, m);
    repeat (12) @(posedge clock_i);
    chk(pin, 2'h0);
  endtask
  task automatic t_setup;
    chk(ap, 4'h1);
    chk(expo, pcs_pkg::EXP_RST);
    wb(1'b0, 8'h40, 32'h0);
    chk(q, pcs_pkg::BAD_ADDR_DATA);
    for (int i = 0; i < 11; i++) wb(1'b1, cfg_a[i], {16'h0, cfg_d[i]});
    chk(expo, 24'h100);
    wb(1'b1, 8'h20, 32'h999);
    wb(1'b0, 8'h20, 32'h0);
    chk(q, 32'h100);
  endtask
  task automatic t_step;
    ev_go(0);
    chk(ap, 4'h1);
    wb(1'b1, 8'h0C, 32'h1001);
    wb(1'b1, 8'h10, 32'h300);
    chk(expo, 24'h100);
    ev_go(0);
    chk(ap, 4'h2);
    chk(expo, 24'h300);
    ev_go(0);
    ev_go(0);
    chk(ap, 4'h1);
    pulse(2'h1);
  endtask
  task automatic t_burst;
    wb(1'b1, 8'h08, 32'h1);
    ev_go(0);
    chk(ap, 4'h2);
    pulse(2'h2);
    ev_go(0);
    chk(ap, 4'h1);
  endtask
  task automatic t_sync;
    wb(1'b1, 8'h04, 32'h3);
    ev_go(0);
    ev_go(3);
    wb(1'b0, 8'h18, 32'h0);
    chk(q, 32'h01000001);
    chk(ap, 4'h2);
    ev_go(0);
    chk(ap, 4'h1);
    wb(1'b1, 8'h00, 32'h111);
    wb(1'b0, 8'h00, 32'h0);
    chk(q, 32'h111);
    ev_go(1);
    chk(ap, 4'h2);
  endtask
  task automatic t_async;
    wb(1'b1, 8'h08, 32'h2);
    wb(1'b1, 8'h00, 32'h241);
    sw(32'h1);
    sw(32'h2);
    chk(ap, 4'h1);
    sw(32'h1);
    chk(ap, 4'h1);
    sw(32'h1);
    chk(ap, 4'h2);
    wb(1'b1, 8'h00, 32'h221);
    ev_go(4);
    ev_go(4);
    chk(ap, 4'h3);
    wb(1'b1, 8'h00, 32'h231);
    ev_go(5);
    ev_go(5);
    chk(ap, 4'h1);
    wb(1'b1, 8'h00, 32'h341);
    sw(32'h1);
    sw(32'h1);
    ev_go(5);
    chk(ap, 4'h1);
    chk(expo, 24'h100);
  endtask
  task automatic t_off;
    wb(1'b1, 8'h00, 32'h0);
    ev_go(0);
    ev_go(0);
    chk(ap, 4'h1);
    chk(expo, pcs_pkg::EXP_RST);
    wb(1'b1, 8'h20, 32'h500);
    wb(1'b0, 8'h20, 32'h0);
    chk(q, 32'h500);
    chk(expo, 24'h500);
  endtask
  initial begin
    repeat (6) @(posedge clock_i);
    srst_i <= 1'b0;
    t_setup();
    t_step();
    t_burst();
    t_sync();
    t_async();
    t_off();
    end_of_test();
  end
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      end_of_test();
    end
  end
endmodule
